/* design/capacitive_sense_control.v */
/*
 capacitive sense control registers and oscillator/timer0 steering.
 assumes a simple one-cycle register port on core_clk, an analog oscillator
 whose direction flag is asynchronous, and a timer0 that takes a clock select.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// What this block does
// - variable mode code 00: noise detection, no current
// - variable mode 01/10/11: low, medium, high range
// - status reads 1 sourcing, 0 sinking
// - external select: sense oscillator or clock pin
// - internal timer0 source uses quarter system clock
// - disabled module connects no channel, but still stores and reads back the select
// - codes 0000-0111 connect channels 0-7
// - small variant lacks upper select bits, channels
// - channel register bits 7-4 read zero
// - all writable fields reset to zero
// - control bit 7 enables the module
// - control bit 6 selects variable reference
// - fixed mode 00 off, else low/medium/high
`timescale 1ns/1ps
`include "sense_consts.vh"
module capacitive_sense_control
#(
    parameter LARGE_VARIANT = 1
)
(
    core_clk,
    rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    osc_sourcing,
    timer0_clock_source_select,
    osc_enable,
    osc_noise_mode,
    osc_range,
    osc_variable_ref,
    channel_connect,
    timer0_clk_sel
);
localparam NUM_CH = LARGE_VARIANT ? 8 : 4;
localparam SEL_W = LARGE_VARIANT ? 4 : 2;
input wire core_clk;
input wire rst;
input wire [`ADDR_W-1:0] reg_addr;
input wire [7:0] reg_wdata;
input wire reg_wr;
input wire reg_rd;
output reg [7:0] reg_rdata;
input wire osc_sourcing;
input wire timer0_clock_source_select;
output reg osc_enable;
output reg osc_noise_mode;
output reg [1:0] osc_range;
output reg osc_variable_ref;
output reg [7:0] channel_connect;
output reg [1:0] timer0_clk_sel;

reg sense_module_enable_q;
reg reference_mode_select_q;
reg [1:0] current_range_select_q;
reg timer0_external_source_select_q;
reg [SEL_W-1:0] sense_channel_select_q;
reg t0cs_meta_q;
reg t0cs_q;
wire dir_sync;
reg [3:0] chsel_full;
wire [NUM_CH-1:0] connect_d;
reg [7:0] ctl_read;
reg [7:0] rdata_d;
reg osc_enable_d;
reg osc_noise_d;
reg [1:0] t0_sel_d;
reg [1:0] osc_range_d;
reg [7:0] connect_wide;
reg ctl_sel;
reg chsel_sel;

level_sync u_dir_sync
(
    .core_clk(core_clk),
    .rst(rst),
    .async_in(osc_sourcing),
    .sync_out(dir_sync)
);

// timer0 select may come from another clock domain, so it is synchronised too
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        t0cs_meta_q <= 1'b0;
        t0cs_q <= 1'b0;
    end
    else
    begin
        t0cs_meta_q <= timer0_clock_source_select;
        t0cs_q <= t0cs_meta_q;
    end
end

always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        sense_module_enable_q <= 1'b0;
        reference_mode_select_q <= 1'b0;
        current_range_select_q <= `RANGE_OFF_OR_NOISE;
        timer0_external_source_select_q <= 1'b0;
        sense_channel_select_q <= {SEL_W{1'b0}};
    end
    else if (reg_wr)
    begin
        if (reg_addr == `OFF_CONTROL_ZERO)
        begin
            sense_module_enable_q <= reg_wdata[`CTL_ENABLE_BIT];
            reference_mode_select_q <= reg_wdata[`CTL_REFMODE_BIT];
            current_range_select_q <= reg_wdata[`CTL_RANGE_HI:`CTL_RANGE_LO];
            timer0_external_source_select_q <= reg_wdata[`CTL_T0SEL_BIT];
        end
        else if (reg_addr == `OFF_CHANNEL_SEL)
        begin
            // upper bits absent on small variant
            sense_channel_select_q <= reg_wdata[SEL_W-1:0];
        end
    end
end

// zero-extend narrow select
// zero default, then the low slice, so the large variant needs no zero-width replication
always @*
begin
    chsel_full = `CHSEL_RESET;
    chsel_full[SEL_W-1:0] = sense_channel_select_q;
end

channel_decode #(.NUM_CHANNELS(NUM_CH)) u_decode
(
    .enable(sense_module_enable_q),
    .code(chsel_full),
    .connect(connect_d)
);

always @*
begin
    connect_wide = 8'h00;
    connect_wide[NUM_CH-1:0] = connect_d;
end

// register address decode for the read path
always @*
begin
    ctl_sel = 1'b0;
    chsel_sel = 1'b0;
    if (reg_addr == `OFF_CONTROL_ZERO)
    begin
        ctl_sel = 1'b1;
    end
    else if (reg_addr == `OFF_CHANNEL_SEL)
    begin
        chsel_sel = 1'b1;
    end
end

// oscillator mode from reference mode and range code
always @*
begin
    osc_enable_d = 1'b0;
    osc_noise_d = 1'b0;
    osc_range_d = current_range_select_q;
    case ({reference_mode_select_q, current_range_select_q})
    3'h0:
    begin
        osc_enable_d = 1'b0;
        osc_range_d = `RANGE_OFF_OR_NOISE;
    end
    3'h1:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_LOW;
    end
    3'h2:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_MEDIUM;
    end
    3'h3:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_HIGH;
    end
    3'h4:
    begin
        // variable 00 keeps running
        // noise detection supplies no current, so no range is passed on
        osc_enable_d = sense_module_enable_q;
        osc_noise_d = sense_module_enable_q;
        osc_range_d = `RANGE_OFF_OR_NOISE;
    end
    3'h5:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_LOW;
    end
    3'h6:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_MEDIUM;
    end
    3'h7:
    begin
        osc_enable_d = sense_module_enable_q;
        osc_range_d = `RANGE_HIGH;
    end
    default:
    begin
        osc_enable_d = 1'b0;
        osc_noise_d = 1'b0;
        osc_range_d = `RANGE_OFF_OR_NOISE;
    end
    endcase
end

// timer0 clock steering
always @*
begin
    t0_sel_d = `T0SRC_QUARTER;
    case ({t0cs_q, timer0_external_source_select_q})
    2'h0, 2'h1:
    begin
        t0_sel_d = `T0SRC_QUARTER;
    end
    2'h2:
    begin
        t0_sel_d = `T0SRC_PIN;
    end
    2'h3:
    begin
        t0_sel_d = `T0SRC_SENSE;
    end
    default:
    begin
        t0_sel_d = `T0SRC_QUARTER;
    end
    endcase
end

always @*
begin
    ctl_read = 8'h00;
    ctl_read[`CTL_ENABLE_BIT] = sense_module_enable_q;
    ctl_read[`CTL_REFMODE_BIT] = reference_mode_select_q;
    ctl_read[`CTL_RANGE_HI:`CTL_RANGE_LO] = current_range_select_q;
    ctl_read[`CTL_DIR_BIT] = dir_sync;
    ctl_read[`CTL_T0SEL_BIT] = timer0_external_source_select_q;
    if (ctl_sel)
    begin
        rdata_d = ctl_read;
    end
    else if (chsel_sel)
    begin
        rdata_d = {4'h0, chsel_full};
    end
    else
    begin
        rdata_d = 8'h00;
    end
end

// read data stand one cycle, zero otherwise
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
        reg_rdata <= rdata_d;
    end
    else
    begin
        reg_rdata <= 8'h00;
    end
end

// oscillator controls registered so the analog side sees clean levels
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        osc_enable <= 1'b0;
        osc_noise_mode <= 1'b0;
        osc_range <= `RANGE_OFF_OR_NOISE;
        osc_variable_ref <= 1'b0;
    end
    else
    begin
        osc_enable <= osc_enable_d;
        osc_noise_mode <= osc_noise_d;
        osc_range <= osc_range_d;
        osc_variable_ref <= reference_mode_select_q;
    end
end

always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        channel_connect <= 8'h00;
    end
    else
    begin
        channel_connect <= connect_wide;
    end
end

always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        timer0_clk_sel <= `T0SRC_QUARTER;
    end
    else
    begin
        timer0_clk_sel <= t0_sel_d;
    end
end
endmodule // capacitive_sense_control

/* design/sense_consts.vh */
/*
 constants for the capacitive sense control block: register offsets,
 field positions, reset values and codes. assumes byte-wide registers.
*/
`ifndef SENSE_CONSTS_VH
`define SENSE_CONSTS_VH

`define ADDR_W 4
`define OFF_CONTROL_ZERO 4'h0
`define OFF_CHANNEL_SEL 4'h1
`define CTL_ENABLE_BIT 7
`define CTL_REFMODE_BIT 6
`define CTL_RANGE_HI 3
`define CTL_RANGE_LO 2
`define CTL_DIR_BIT 1
`define CTL_T0SEL_BIT 0
`define CTL_WRITE_MASK 8'hCD
`define CTL_RESET 8'h00
`define CHSEL_RESET 4'h0
`define RANGE_OFF_OR_NOISE 2'h0
`define RANGE_LOW 2'h1
`define RANGE_MEDIUM 2'h2
`define RANGE_HIGH 2'h3
`define T0SRC_QUARTER 2'h0
`define T0SRC_PIN 2'h1
`define T0SRC_SENSE 2'h2

`endif

/* design/level_sync.v */
/*
 two-flop synchroniser for one level.
 assumes the input is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module level_sync
(
    core_clk,
    rst,
    async_in,
    sync_out
);
input wire core_clk;
input wire rst;
input wire async_in;
output wire sync_out;
reg meta_q;
reg sync_q;
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
    end
    else
    begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end
assign sync_out = sync_q;
endmodule // level_sync

/* design/channel_decode.v */
/*
 one-hot channel connect decoder.
 assumes code is a registered select and enable a registered bit.
*/
`timescale 1ns/1ps
module channel_decode
#(
    parameter NUM_CHANNELS = 8
)
(
    enable,
    code,
    connect
);
input wire enable;
input wire [3:0] code;
output reg [NUM_CHANNELS-1:0] connect;
integer i;
always @*
begin
    connect = {NUM_CHANNELS{1'b0}};
    for (i = 0; i < NUM_CHANNELS; i = i + 1)
    begin
        if (enable && (code == i[3:0]))
        begin
            connect[i] = 1'b1;
        end
    end
end
endmodule // channel_decode

/* tb/sense_osc_model.sv */
/*
 behavioural sense oscillator: flips current direction at a range-set rate.
 assumes registered controls from the block; holds its level when stopped.
*/
`timescale 1ns/1ps
module sense_osc_model
(
    input wire core_clk,
    input wire osc_enable,
    input wire [1:0] osc_range,
    output logic osc_sourcing
);
logic [4:0] phase_q = 5'h00;
// more current charges the pad faster, so the direction flips sooner
always @(posedge core_clk)
begin
    if (osc_enable)
        phase_q <= phase_q + 5'h01 + {3'h0, osc_range};
end
assign osc_sourcing = phase_q[4];
endmodule // sense_osc_model

/* tb/sense_ctl_chk.sv */
/*
 port assertions for the sense control block.
 assumes it is bound into capacitive_sense_control.
*/
`timescale 1ns/1ps
`include "sense_consts.vh"
module sense_ctl_chk
(
    input wire core_clk,
    input wire rst,
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire osc_sourcing,
    input wire timer0_clock_source_select,
    input wire osc_enable,
    input wire osc_noise_mode,
    input wire [1:0] osc_range,
    input wire osc_variable_ref,
    input wire [7:0] channel_connect,
    input wire [1:0] timer0_clk_sel
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
wire wr0 = reg_wr && reg_addr == 4'h0;
wire tcs = timer0_clock_source_select;
// two quiet cycles so either output latency has landed
sequence quiet_wr0;
    wr0 ##1 !wr0 [*2];
endsequence
a_noise_mode:
    assert property (osc_noise_mode |-> osc_enable && osc_variable_ref && osc_range == 2'h0)
    else $error("noise mode outside variable range zero");
a_fixed_off:
    assert property (osc_enable && !osc_variable_ref |-> osc_range != 2'h0)
    else $error("fixed mode running at range zero");
a_ref_follow:
    assert property (quiet_wr0 |=> osc_variable_ref == $past(reg_wdata[6], 3))
    else $error("reference mode not taken");
a_range_follow:
    assert property (quiet_wr0 |=> osc_range == $past(reg_wdata[3:2], 3))
    else $error("range not taken");
a_enable_follow:
    assert property (quiet_wr0 |=> osc_enable == ($past(reg_wdata[7], 3) &&
        ($past(reg_wdata[6], 3) || $past(reg_wdata[3:2], 3) != 2'h0)))
    else $error("enable not taken");
a_one_channel:
    assert property ($onehot0(channel_connect))
    else $error("several channels connected");
a_chan_hi_zero:
    assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:4] == 4'h0)
    else $error("channel register high bits set");
a_tmr_quarter:
    assert property (!tcs [*4] |-> timer0_clk_sel == 2'h0)
    else $error("timer0 not on quarter clock");
a_tmr_external:
    assert property (tcs [*4] |-> timer0_clk_sel == 2'h1 || timer0_clk_sel == 2'h2)
    else $error("timer0 not on an external source");
a_status_read:
    assert property ($stable(osc_sourcing) [*3] ##0 wr0 == 1'b0 && reg_rd &&
        reg_addr == 4'h0 |=> reg_rdata[1] == $past(osc_sourcing))
    else $error("status bit wrong");
cover property (osc_noise_mode);
cover property (tcs && timer0_clk_sel == 2'h2);
cover property (channel_connect[7]);
endmodule // sense_ctl_chk
bind capacitive_sense_control sense_ctl_chk u_chk (.*);

/* tb/capacitive_sense_control_tb_top.sv */
/*
 self-checking bench for the sense control block.
 assumes the oscillator model and the bound checker.
*/
`timescale 1ns/1ps
module capacitive_sense_control_tb_top;
logic core_clk, rst, reg_wr, reg_rd, osc_sourcing, timer0_clock_source_select;
logic [3:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata, channel_connect, d;
logic osc_enable, osc_noise_mode, osc_variable_ref;
logic [1:0] osc_range, timer0_clk_sel;
int miscompares, tests_run;
capacitive_sense_control u_dut (.*);
sense_osc_model u_osc (.*);
initial
begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
end
task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
        miscompares++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
endtask
task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata & m);
endtask
function automatic logic [7:0] exp_osc(input logic [7:0] v);
    logic en;
    en = v[7] && (v[6] || v[3:2] != 2'h0);
    return {3'h0, en, en && v[6] && v[3:2] == 2'h0, v[6], v[3:2]};
endfunction
task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
initial
begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
end
initial
begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    timer0_clock_source_select = 1'b0;
    void'($urandom(25487));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, 8'hFD, 8'h00, "ctl reset");
    rd(4'h1, 8'hFF, 8'h00, "chan reset");
    for (int i = 0; i < 16; i++)
    begin
        d = $urandom;
        d[7:6] = i[3:2];
        d[3:2] = i[1:0];
        wr(4'h0, d);
        chk("osc", exp_osc(d), {3'h0, osc_enable, osc_noise_mode, osc_variable_ref, osc_range});
        rd(4'h0, 8'hFD, d & 8'hCD, "ctl read");
    end
    for (int i = 0; i < 16; i++)
    begin
        wr(4'h0, {i[3], 7'h00});
        d = $urandom;
        // software keeps to the defined codes
        d[3:0] = {1'b0, i[2:0]};
        wr(4'h1, d);
        chk("connect", i[3] ? 8'h01 << d[2:0] : 8'h00, channel_connect);
        rd(4'h1, 8'hFF, d & 8'h0F, "chan read");
    end
    for (int i = 0; i < 4; i++)
    begin
        @(posedge core_clk);
        timer0_clock_source_select <= i[1];
        wr(4'h0, {7'h00, i[0]});
        chk("t0 src", i[1] ? (i[0] ? 8'h02 : 8'h01) : 8'h00, {6'h0, timer0_clk_sel});
    end
    for (int i = 0; i < 8; i++)
    begin
        wr(4'h0, 8'hC0);
        repeat ($urandom_range(1, 40)) @(posedge core_clk);
        // stopping the oscillator holds its direction still for the read
        wr(4'h0, 8'h02);
        rd(4'h0, 8'hFF, {6'h00, osc_sourcing, 1'b0}, "status");
    end
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'hFF, 8'h00, "unmapped");
    rd(4'h0, 8'hFD, 8'h00, "ctl kept");
    report_and_stop;
end
endmodule // capacitive_sense_control_tb_top
